// *** rtl/bsq_pkg.sv ***
// constants, states and carrier types for the boost sequencer and serial port
// Functional notes
// - skip pulses while output above reference
// - block both paths while boost is off
// - rising enable with battery ok starts precharge
// - precharge timeout enters boost fault
// - mid node ok leaves precharge into soft start
// - soft start timeout enters boost fault
// - switch off while feedback above reference in run, not in soft start
// - fault clears select, stage high-z, sets code
// - no restart unless pin path enabled
// - pin path restarts after delay, then retries
// - aux regulator gated by disable, node, boost
// - monitor register shows live conditions
// - data line only pulled low, clock input
// - bytes move msb first, sampled on rise
// - answer only the fixed slave address
// - high-speed master code is never acknowledged
// - high-speed held until the first start after a stop condition
// - request pin active level set by polarity
// - pin request overrides high-z; high-z beats select
package bsq_pkg;
	// register offsets
	localparam logic [7:0] REG_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] REG_CONTROL_ONE = 8'h01;
	localparam logic [7:0] REG_OUTPUT_REGULATION_SETTING = 8'h02;
	localparam logic [7:0] REG_CHIP_IDENTITY = 8'h03;
	localparam logic [7:0] REG_BATTERY_CURRENT_SETTING = 8'h04;
	localparam logic [7:0] REG_CONTROL_FIVE = 8'h05;
	localparam logic [7:0] REG_REGISTER_SEVEN = 8'h07;
	localparam logic [7:0] REG_LIVE_STATUS_MONITOR = 8'h10;
	// reset values
	localparam logic [7:0] RST_CONTROL_ZERO = 8'h40;
	localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_OUTPUT_REGULATION_SETTING = 8'h0A;
	localparam logic [7:0] RST_BATTERY_CURRENT_SETTING = 8'h89;
	localparam logic [7:0] RST_CONTROL_FIVE = 8'h00;
	localparam logic [7:0] RST_REGISTER_SEVEN = 8'h01;
	// field positions
	localparam int FLD_BOOST_SELECT_BIT = 0;
	localparam int FLD_HIGH_IMPEDANCE_SELECT = 1;
	localparam int FLD_AUX_REGULATOR_DISABLE = 6;
	localparam logic [2:0] FAULT_CODE_BOOST = 3'h1;
	// serial port
	localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD4;
	localparam logic [4:0] HS_MASTER_CODE_TOP = 5'h01;
	// timing, times in ns
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_PRECHARGE_NS = 500000;
	localparam int T_SOFT_START_NS = 128000;
	localparam int T_RESTART_NS = 5200000;
	localparam int T_RETRY_NS = 10000000;
	localparam int CNT_W = 24;

	typedef enum logic [2:0] {
		BSQ_OFF,
		BSQ_PRECHARGE,
		BSQ_SOFT_START,
		BSQ_RUN,
		BSQ_FAULT_WAIT
	} bsq_boost_e;

	typedef enum logic [2:0] {
		BSQ_IDLE,
		BSQ_ADDR,
		BSQ_REG_ADDR,
		BSQ_WR_DATA,
		BSQ_RD_DATA
	} bsq_phase_e;

	// analog comparator levels
	typedef struct packed {
		logic bat_above_uvlo;
		logic mid_above_margin;
		logic mid_above_bat;
		logic out_at_setpoint;
		logic out_above_ref;
		logic valley_zero;
		logic fb_above_ref;
		logic stage_fault;
	} bsq_ana_s;

	// power stage controls
	typedef struct packed {
		logic path_block;
		logic precharge_src;
		logic softstart_mod;
		logic switch_on;
		logic stage_hiz;
		logic aux_reg_en;
	} bsq_stage_s;
endpackage

// *** rtl/bsq_boost_sequencer.sv ***
// boost startup sequencer, fault restart and serial register port
`timescale 1ns/1ps
module bsq_boost_sequencer
	import bsq_pkg::*;
#(
	parameter logic [CNT_W-1:0] PRECHG_CYC = CNT_W'(T_PRECHARGE_NS / CLK_PERIOD_NS),
	parameter logic [CNT_W-1:0] SS_CYC = CNT_W'(T_SOFT_START_NS / CLK_PERIOD_NS),
	parameter logic [CNT_W-1:0] RESTART_CYC =
		CNT_W'((T_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
	parameter logic [CNT_W-1:0] RETRY_CYC = CNT_W'(T_RETRY_NS / CLK_PERIOD_NS),
	parameter logic [7:0] CHIP_ID = 8'h5A // arbitrary value
) (
	// system
	input wire logic clock,
	input wire logic rst_b,
	// serial bus, link clock
	input wire logic serial_clk,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic hs_mode_active,
	// boost request pin and loose controls
	input wire logic boost_request_pin,
	input wire logic request_pin_enable,
	input wire logic request_pin_polarity,
	// analog conditions
	input wire bsq_ana_s ana_in,
	// power stage
	output bsq_stage_s stage_out,
	output logic pfm_active
);
	// ---------------- link domain ----------------
	typedef struct packed {
		bsq_phase_e phase;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic oe;
		logic hs;
		logic hs_pend;
		logic [7:0] reg_addr;
		logic wr_tgl;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic rd_tgl;
		logic [7:0] rd_addr;
		logic stop_seen;
	} bsq_link_s;

	typedef struct packed {
		bsq_boost_e st;
		logic [CNT_W-1:0] cnt;
		logic retried;
		logic req_prev;
		logic pfm;
		bsq_ana_s ana_s1;
		bsq_ana_s ana_s2;
		logic pin_s1;
		logic pin_s2;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] wr_s;
		logic [2:0] rd_s;
		logic stop_tgl;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] output_regulation_setting;
		logic [7:0] battery_current_setting;
		logic [7:0] ctrl5;
		logic [7:0] reg7;
		logic [7:0] rd_data;
		bsq_stage_s stage;
	} bsq_main_s;

	logic rx_bit_ff;
	bsq_link_s link_ff;
	bsq_link_s nxt_link;
	bsq_main_s main_ff;
	bsq_main_s nxt_main;
	logic [7:0] rx_byte;
	logic start_seen;
	logic stop_pend;

	// data sampled on the rising clock edge
	always_ff @(posedge serial_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_bit_ff <= 1'b1;
		end else begin
			rx_bit_ff <= serial_data_in;
		end
	end

	// stop toggle from the system side, settled long before the next start falls
	assign stop_pend = main_ff.stop_tgl ^ link_ff.stop_seen;
	// data high at the last rise, or bus freed by a stop, then low at the fall
	assign start_seen = (rx_bit_ff | stop_pend) & ~serial_data_in;
	assign rx_byte = {link_ff.sh[6:0], rx_bit_ff};

	always_comb begin
		nxt_link = link_ff;
		if (start_seen) begin
			nxt_link.phase = BSQ_ADDR;
			nxt_link.cnt = 4'h0;
			nxt_link.oe = 1'b0;
			nxt_link.stop_seen = main_ff.stop_tgl;
			if (stop_pend) begin
				// leave high speed only after a stop
				nxt_link.hs = 1'b0;
				nxt_link.hs_pend = 1'b0;
			end else if (link_ff.hs_pend) begin
				nxt_link.hs = 1'b1;
				nxt_link.hs_pend = 1'b0;
			end
		end else begin
			case (link_ff.phase)
				BSQ_IDLE: begin
					nxt_link.oe = 1'b0;
				end
				BSQ_RD_DATA: begin
					if (link_ff.cnt < 4'h7) begin
						// shift out msb first, low only
						nxt_link.oe = ~link_ff.sh[7];
						nxt_link.sh = {link_ff.sh[6:0], 1'b0};
						nxt_link.cnt = link_ff.cnt + 4'h1;
					end else if (link_ff.cnt == 4'h7) begin
						nxt_link.oe = 1'b0;
						nxt_link.cnt = 4'h8;
						// prefetch the next register
						nxt_link.reg_addr = link_ff.reg_addr + 8'h01;
						nxt_link.rd_addr = link_ff.reg_addr + 8'h01;
						nxt_link.rd_tgl = ~link_ff.rd_tgl;
					end else if (rx_bit_ff) begin
						// master refused the byte
						nxt_link.phase = BSQ_IDLE;
						nxt_link.oe = 1'b0;
						nxt_link.cnt = 4'h0;
					end else begin
						nxt_link.oe = ~main_ff.rd_data[7];
						nxt_link.sh = {main_ff.rd_data[6:0], 1'b0};
						nxt_link.cnt = 4'h0;
					end
				end
				default: begin
					if (link_ff.cnt < 4'h7) begin
						nxt_link.sh = rx_byte;
						nxt_link.cnt = link_ff.cnt + 4'h1;
					end else if (link_ff.cnt == 4'h7) begin
						nxt_link.sh = rx_byte;
						nxt_link.cnt = 4'h8;
						nxt_link.oe = 1'b0;
						case (link_ff.phase)
							BSQ_ADDR: begin
								if (rx_byte[7:3] == HS_MASTER_CODE_TOP && !link_ff.hs) begin
									// master code, no acknowledge
									nxt_link.hs_pend = 1'b1;
									nxt_link.phase = BSQ_IDLE;
								end else if (rx_byte[7:1] == SLAVE_ADDR_BYTE[7:1]) begin
									nxt_link.oe = 1'b1;
									if (rx_byte[0]) begin
										// read after repeated start
										nxt_link.rd_addr = link_ff.reg_addr;
										nxt_link.rd_tgl = ~link_ff.rd_tgl;
									end
								end else begin
									nxt_link.phase = BSQ_IDLE;
								end
							end
							BSQ_REG_ADDR: begin
								nxt_link.oe = 1'b1;
								nxt_link.reg_addr = rx_byte;
							end
							BSQ_WR_DATA: begin
								nxt_link.oe = 1'b1;
								nxt_link.wr_addr = link_ff.reg_addr;
								nxt_link.wr_data = rx_byte;
								nxt_link.wr_tgl = ~link_ff.wr_tgl;
								nxt_link.reg_addr = link_ff.reg_addr + 8'h01;
							end
							default: begin
								nxt_link.phase = BSQ_IDLE;
							end
						endcase
					end else begin
						// end of acknowledge bit
						nxt_link.oe = 1'b0;
						nxt_link.cnt = 4'h0;
						case (link_ff.phase)
							BSQ_ADDR: begin
								if (link_ff.sh[0]) begin
									nxt_link.phase = BSQ_RD_DATA;
									nxt_link.oe = ~main_ff.rd_data[7];
									nxt_link.sh = {main_ff.rd_data[6:0], 1'b0};
								end else begin
									nxt_link.phase = BSQ_REG_ADDR;
								end
							end
							BSQ_REG_ADDR: begin
								nxt_link.phase = BSQ_WR_DATA;
							end
							default: begin
								nxt_link.phase = link_ff.phase;
							end
						endcase
					end
				end
			endcase
		end
	end

	// outputs change only after the falling edge
	always_ff @(negedge serial_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_ff <= '0;
		end else begin
			link_ff <= nxt_link;
		end
	end

	assign serial_data_out = 1'b0;
	assign serial_data_oe = link_ff.oe;
	assign hs_mode_active = link_ff.hs;

	// ---------------- system domain ----------------
	logic pin_active;
	logic boost_req;
	logic fault_evt;
	logic stop_evt;
	logic wr_evt;
	logic rd_evt;
	logic [7:0] monitor;
	logic [7:0] rd_mux;

	assign pin_active = (main_ff.pin_s2 == request_pin_polarity);
	// pin path beats high-z, high-z beats select
	assign boost_req = (request_pin_enable & pin_active) |
		(main_ff.ctrl1[FLD_BOOST_SELECT_BIT] & ~main_ff.ctrl1[FLD_HIGH_IMPEDANCE_SELECT]);
	assign stop_evt = main_ff.scl_s[1] & main_ff.scl_s[2] & main_ff.sda_s[1] & ~main_ff.sda_s[2];
	assign wr_evt = main_ff.wr_s[1] ^ main_ff.wr_s[2];
	assign rd_evt = main_ff.rd_s[1] ^ main_ff.rd_s[2];

	// live status, not latched
	assign monitor = {pin_active, main_ff.ana_s2.bat_above_uvlo, main_ff.ana_s2.out_above_ref,
		main_ff.ana_s2.mid_above_bat, main_ff.st == BSQ_PRECHARGE,
		main_ff.st == BSQ_SOFT_START, main_ff.st == BSQ_RUN, main_ff.pfm};

	always_comb begin
		case (link_ff.rd_addr)
			REG_CONTROL_ZERO: rd_mux = main_ff.ctrl0;
			REG_CONTROL_ONE: rd_mux = main_ff.ctrl1;
			REG_OUTPUT_REGULATION_SETTING: rd_mux = main_ff.output_regulation_setting;
			REG_CHIP_IDENTITY: rd_mux = CHIP_ID;
			REG_BATTERY_CURRENT_SETTING: rd_mux = main_ff.battery_current_setting;
			REG_CONTROL_FIVE: rd_mux = main_ff.ctrl5;
			REG_REGISTER_SEVEN: rd_mux = main_ff.reg7;
			REG_LIVE_STATUS_MONITOR: rd_mux = monitor;
			default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		nxt_main = main_ff;
		fault_evt = 1'b0;
		nxt_main.ana_s1 = ana_in;
		nxt_main.ana_s2 = main_ff.ana_s1;
		nxt_main.pin_s1 = boost_request_pin;
		nxt_main.pin_s2 = main_ff.pin_s1;
		nxt_main.scl_s = {main_ff.scl_s[1:0], serial_clk};
		nxt_main.sda_s = {main_ff.sda_s[1:0], serial_data_in};
		nxt_main.wr_s = {main_ff.wr_s[1:0], link_ff.wr_tgl};
		nxt_main.rd_s = {main_ff.rd_s[1:0], link_ff.rd_tgl};
		nxt_main.req_prev = boost_req;
		if (stop_evt) begin
			nxt_main.stop_tgl = ~main_ff.stop_tgl;
		end
		if (rd_evt) begin
			nxt_main.rd_data = rd_mux;
		end
		if (wr_evt) begin
			case (link_ff.wr_addr)
				REG_CONTROL_ZERO: nxt_main.ctrl0[7:3] = link_ff.wr_data[7:3];
				REG_CONTROL_ONE: nxt_main.ctrl1 = link_ff.wr_data;
				REG_OUTPUT_REGULATION_SETTING: nxt_main.output_regulation_setting = link_ff.wr_data;
				REG_BATTERY_CURRENT_SETTING: nxt_main.battery_current_setting = link_ff.wr_data;
				REG_CONTROL_FIVE: nxt_main.ctrl5 = link_ff.wr_data;
				REG_REGISTER_SEVEN: nxt_main.reg7 = link_ff.wr_data;
				default: nxt_main.ctrl0 = main_ff.ctrl0;
			endcase
		end
		// one counter, cleared on entry to each timed state, held at zero in off and run
		nxt_main.cnt = main_ff.cnt + CNT_W'(1);
		case (main_ff.st)
			BSQ_OFF: begin
				nxt_main.cnt = '0;
				if (boost_req && !main_ff.req_prev && main_ff.ana_s2.bat_above_uvlo) begin
					nxt_main.st = BSQ_PRECHARGE;
				end
			end
			BSQ_PRECHARGE: begin
				if (!boost_req) begin
					nxt_main.st = BSQ_OFF;
				end else if (main_ff.ana_s2.mid_above_margin) begin
					nxt_main.st = BSQ_SOFT_START;
					nxt_main.cnt = '0;
				end else if (main_ff.cnt == PRECHG_CYC - CNT_W'(1)) begin
					fault_evt = 1'b1;
				end
			end
			BSQ_SOFT_START: begin
				if (!boost_req) begin
					nxt_main.st = BSQ_OFF;
				end else if (main_ff.ana_s2.out_at_setpoint) begin
					nxt_main.st = BSQ_RUN;
					nxt_main.retried = 1'b0;
				end else if (main_ff.cnt == SS_CYC - CNT_W'(1)) begin
					fault_evt = 1'b1;
				end
			end
			BSQ_RUN: begin
				nxt_main.cnt = '0;
				if (!boost_req) begin
					nxt_main.st = BSQ_OFF;
				end else if (main_ff.ana_s2.stage_fault) begin
					fault_evt = 1'b1;
				end
			end
			BSQ_FAULT_WAIT: begin
				if (!(request_pin_enable && pin_active)) begin
					// select path needs a new host write
					nxt_main.st = BSQ_OFF;
					nxt_main.cnt = '0;
				end else if (main_ff.cnt == (main_ff.retried ? RETRY_CYC : RESTART_CYC)
						- CNT_W'(1)) begin
					nxt_main.st = BSQ_PRECHARGE;
					nxt_main.retried = 1'b1;
					nxt_main.cnt = '0;
				end
			end
			default: begin
				nxt_main.st = BSQ_OFF;
			end
		endcase
		if (fault_evt) begin
			nxt_main.st = BSQ_FAULT_WAIT;
			nxt_main.cnt = '0;
			nxt_main.ctrl1[FLD_BOOST_SELECT_BIT] = 1'b0;
			nxt_main.ctrl0[2:0] = FAULT_CODE_BOOST;
		end
		// pulse skip entry and exit
		if (nxt_main.st != BSQ_RUN) begin
			nxt_main.pfm = 1'b0;
		end else if (main_ff.ana_s2.valley_zero && main_ff.ana_s2.out_above_ref) begin
			nxt_main.pfm = 1'b1;
		end else if (!main_ff.ana_s2.valley_zero && !main_ff.ana_s2.out_above_ref) begin
			nxt_main.pfm = 1'b0;
		end
		// stage controls follow the next state
		nxt_main.stage.path_block = (nxt_main.st == BSQ_OFF) ||
			(nxt_main.st == BSQ_FAULT_WAIT);
		nxt_main.stage.precharge_src = (nxt_main.st == BSQ_PRECHARGE);
		nxt_main.stage.softstart_mod = (nxt_main.st == BSQ_SOFT_START);
		nxt_main.stage.switch_on = ((nxt_main.st == BSQ_RUN) && !main_ff.ana_s2.fb_above_ref &&
			!(nxt_main.pfm && main_ff.ana_s2.out_above_ref)) ||
			(nxt_main.st == BSQ_SOFT_START);
		nxt_main.stage.stage_hiz = (nxt_main.st == BSQ_FAULT_WAIT);
		nxt_main.stage.aux_reg_en = !nxt_main.ctrl5[FLD_AUX_REGULATOR_DISABLE] &&
			main_ff.ana_s2.mid_above_bat && nxt_main.stage.path_block &&
			!nxt_main.ctrl1[FLD_HIGH_IMPEDANCE_SELECT];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			main_ff <= '{
				st: BSQ_OFF,
				cnt: '0,
				retried: 1'b0,
				req_prev: 1'b0,
				pfm: 1'b0,
				ana_s1: '0,
				ana_s2: '0,
				pin_s1: 1'b0,
				pin_s2: 1'b0,
				scl_s: 3'h7,
				sda_s: 3'h7,
				wr_s: 3'h0,
				rd_s: 3'h0,
				stop_tgl: 1'b0,
				ctrl0: RST_CONTROL_ZERO,
				ctrl1: RST_CONTROL_ONE,
				output_regulation_setting: RST_OUTPUT_REGULATION_SETTING,
				battery_current_setting: RST_BATTERY_CURRENT_SETTING,
				ctrl5: RST_CONTROL_FIVE,
				reg7: RST_REGISTER_SEVEN,
				rd_data: 8'h00,
				stage: '{path_block: 1'b1, default: 1'b0}
			};
		end else begin
			main_ff <= nxt_main;
		end
	end

	assign stage_out = main_ff.stage;
	assign pfm_active = main_ff.pfm;
endmodule

// *** sim/bsq_boost_sequencer_sva.sv ***
// port assertions for the boost sequencer and serial port
`timescale 1ns/1ps
module bsq_boost_sequencer_sva
	import bsq_pkg::*;
#(
	parameter logic [CNT_W-1:0] PRECHG_CYC = CNT_W'(20),
	parameter logic [CNT_W-1:0] SS_CYC = CNT_W'(16)
) (
	// system
	input wire logic clock,
	input wire logic rst_b,
	// serial bus
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic hs_mode_active,
	// request pin
	input wire logic boost_request_pin,
	input wire logic request_pin_enable,
	input wire logic request_pin_polarity,
	// analog and stage
	input wire bsq_ana_s ana_in,
	input wire bsq_stage_s stage_out,
	input wire logic pfm_active
);
	logic [CNT_W-1:0] pc_ff;
	logic [CNT_W-1:0] ss_ff;
	logic run;
	assign run = !stage_out.path_block && !stage_out.precharge_src
		&& !stage_out.softstart_mod && !stage_out.stage_hiz;
	// consecutive cycles spent in precharge and soft start
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_ff <= '0;
			ss_ff <= '0;
		end else begin
			pc_ff <= stage_out.precharge_src ? pc_ff + 1'h1 : '0;
			ss_ff <= stage_out.softstart_mod ? ss_ff + 1'h1 : '0;
		end
	end
	a_oe_low_only: assert property (@(posedge clock) disable iff (!rst_b)
		serial_data_oe |-> !serial_data_out) else $error("data line driven high");
	a_oe_scl_high: assert property (@(posedge clock) disable iff (!rst_b)
		serial_clk && $past(serial_clk) |-> $stable(serial_data_oe))
		else $error("data line moved while clock high");
	a_block_when_off: assert property (@(posedge clock) disable iff (!rst_b)
		stage_out.path_block |-> !stage_out.switch_on && !stage_out.softstart_mod)
		else $error("switching while paths blocked");
	a_prechg_form: assert property (@(posedge clock) disable iff (!rst_b)
		stage_out.precharge_src |-> !stage_out.path_block && !stage_out.switch_on)
		else $error("precharge outputs wrong");
	a_prechg_limit: assert property (@(posedge clock) disable iff (!rst_b)
		pc_ff <= PRECHG_CYC + 2) else $error("precharge overran its timeout");
	a_ss_limit: assert property (@(posedge clock) disable iff (!rst_b)
		ss_ff <= SS_CYC + 2) else $error("soft start overran its timeout");
	a_ss_after_pre: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(stage_out.softstart_mod) |-> $past(stage_out.precharge_src))
		else $error("soft start without precharge");
	a_fb_switch_off: assert property (@(posedge clock) disable iff (!rst_b)
		ana_in.fb_above_ref [*5] ##0 run |-> !stage_out.switch_on)
		else $error("switch on with feedback above reference");
	a_fault_hiz: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(stage_out.stage_hiz) |-> stage_out.path_block && !stage_out.switch_on)
		else $error("fault stage not high impedance");
	a_aux_off_boost: assert property (@(posedge clock) disable iff (!rst_b)
		stage_out.aux_reg_en |-> stage_out.path_block && !stage_out.precharge_src
		&& !stage_out.softstart_mod) else $error("aux output on during boost");
	a_pfm_in_run: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(pfm_active) |-> !stage_out.path_block && !stage_out.softstart_mod
		&& !stage_out.precharge_src) else $error("pulse skip outside run");
endmodule

// *** sim/bsq_host_model.sv ***
// serial bus master standing in for the host processor
`timescale 1ns/1ps
module bsq_host_model (
	// bus lines
	output logic scl,
	output logic sda_rel,
	input wire logic sda
);
	int qt = 40;
	initial begin
		scl = 1'h1;
		sda_rel = 1'h1;
	end
	// start or repeated start
	task automatic start();
		sda_rel = 1'h1;
		#(qt) scl = 1'h1;
		#(qt) sda_rel = 1'h0;
		#(qt) scl = 1'h0;
		#(qt);
	endtask
	// clock stands still after the stop
	task automatic stop();
		sda_rel = 1'h0;
		#(qt) scl = 1'h1;
		#(qt) sda_rel = 1'h1;
		#(qt);
	endtask
	// eight bits then the acknowledge slot, bit 8 first
	task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_rel = tx[i];
			#(qt) scl = 1'h1;
			#1 rx[i] = sda;
			#(2 * qt - 1) scl = 1'h0;
			#(qt);
		end
	endtask
endmodule

// *** sim/bsq_boost_sequencer_test.sv ***
// testbench for the boost sequencer and its serial port
`timescale 1ns/1ps
module bsq_boost_sequencer_test;
	import bsq_pkg::*;
	localparam logic [CNT_W-1:0] PRE = CNT_W'(20);
	localparam logic [CNT_W-1:0] SSC = CNT_W'(16);
	localparam logic [CNT_W-1:0] RST_C = CNT_W'(40);
	localparam logic [CNT_W-1:0] RTY = CNT_W'(60);
	localparam logic [7:0] ID = 8'h3C; // arbitrary value
	localparam int B_HIZ = 1;
	localparam int B_SS = 3;
	localparam int B_PRE = 4;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic pin = 1'h0;
	logic pin_en = 1'h0;
	logic pin_pol = 1'h1;
	bsq_ana_s ana = '0;
	bsq_stage_s stage;
	logic pfm, oe, dout, hs, scl, sda_rel;
	wire sda = sda_rel & (oe ? dout : 1'h1);
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	logic [8:0] rx;
	logic [7:0] offs [6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h07, 8'h20};
	logic [7:0] vals [6] = '{8'h40, 8'h0A, ID, 8'h89, 8'h01, 8'h00};
	always #12.5 clock = ~clock;
	bsq_host_model host_i (.scl(scl), .sda_rel(sda_rel), .sda(sda));
	bsq_boost_sequencer #(.PRECHG_CYC(PRE), .SS_CYC(SSC), .RESTART_CYC(RST_C),
		.RETRY_CYC(RTY), .CHIP_ID(ID)) bsq_boost_sequencer_i (.clock(clock),
		.rst_b(rst_b), .serial_clk(scl), .serial_data_in(sda), .serial_data_out(dout),
		.serial_data_oe(oe), .hs_mode_active(hs), .boost_request_pin(pin),
		.request_pin_enable(pin_en), .request_pin_polarity(pin_pol), .ana_in(ana),
		.stage_out(stage), .pfm_active(pfm));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clock);
		#2;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		host_i.start();
		host_i.byte9({SLAVE_ADDR_BYTE, 1'h1}, rx);
		chk("address ack", 1'h0, rx[0]);
		host_i.byte9({a, 1'h1}, rx);
		host_i.byte9({v, 1'h1}, rx);
		host_i.stop();
		tick(1);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
		host_i.start();
		host_i.byte9({SLAVE_ADDR_BYTE, 1'h1}, rx);
		host_i.byte9({a, 1'h1}, rx);
		host_i.start();
		host_i.byte9({SLAVE_ADDR_BYTE | 8'h01, 1'h1}, rx);
		host_i.byte9(9'h1FF, rx);
		host_i.stop();
		chk("read data", e, rx[8:1] & m);
		tick(1);
	endtask
	task automatic wait_bit(int b, logic v, int lim);
		n = 0;
		while (stage[b] !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk("stage wait", 1'h1, n < lim);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 25000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		tick(12);
		rst_b = 1'h1;
		tick(4);
		foreach (offs[i]) rd(offs[i], 8'hFF, vals[i]);
		wr(8'h02, 8'h8C);
		rd(8'h02, 8'hFF, 8'h8C);
		wr(8'h03, 8'h11);
		rd(8'h03, 8'hFF, ID);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'hFF, 8'hF8);
		host_i.start();
		host_i.byte9({8'hD6, 1'h1}, rx);
		host_i.stop();
		chk("foreign ack", 1'h1, rx[0]);
		// master code at a slow rate, then high speed
		host_i.qt = 300;
		host_i.start();
		host_i.byte9({8'h08, 1'h1}, rx);
		host_i.qt = 40;
		chk("master code ack", 1'h1, rx[0]);
		host_i.start();
		host_i.byte9({SLAVE_ADDR_BYTE, 1'h1}, rx);
		host_i.byte9({8'h07, 1'h1}, rx);
		host_i.byte9({8'h05, 1'h1}, rx);
		chk("high speed", 1'h1, hs);
		host_i.start();
		host_i.byte9({SLAVE_ADDR_BYTE, 1'h1}, rx);
		chk("high speed after sr", 1'h1, hs);
		host_i.stop();
		rd(8'h07, 8'hFF, 8'h05);
		chk("high speed after stop", 1'h0, hs);
		// aux output and live monitor while off
		tick(1);
		ana.mid_above_bat = 1'h1;
		tick(6);
		chk("paths blocked", 1'h1, stage.path_block);
		chk("aux on", 1'h1, stage.aux_reg_en);
		rd(8'h10, 8'h10, 8'h10);
		wr(8'h01, 8'h02);
		tick(6);
		chk("aux hiz", 1'h0, stage.aux_reg_en);
		wr(8'h01, 8'h00);
		wr(8'h05, 8'h40);
		tick(6);
		chk("aux disabled", 1'h0, stage.aux_reg_en);
		wr(8'h05, 8'h00);
		tick(1);
		ana.mid_above_bat = 1'h0;
		rd(8'h10, 8'h10, 8'h00);
		// boost by the select bit through to run and fault
		ana.bat_above_uvlo = 1'h1;
		wr(8'h01, 8'h01);
		wait_bit(B_PRE, 1'h1, 20);
		ana.mid_above_margin = 1'h1;
		wait_bit(B_SS, 1'h1, 10);
		ana.out_at_setpoint = 1'h1;
		wait_bit(B_SS, 1'h0, 10);
		tick(5);
		chk("switch on", 1'h1, stage.switch_on);
		ana.fb_above_ref = 1'h1;
		tick(6);
		chk("switch off fb", 1'h0, stage.switch_on);
		ana.fb_above_ref = 1'h0;
		ana.valley_zero = 1'h1;
		ana.out_above_ref = 1'h1;
		tick(6);
		chk("pulse skip", 1'h1, pfm);
		chk("pulse inhibit", 1'h0, stage.switch_on);
		ana.out_above_ref = 1'h0;
		tick(6);
		chk("burst pulse", 1'h1, stage.switch_on);
		ana.stage_fault = 1'h1;
		wait_bit(B_HIZ, 1'h1, 10);
		rd(8'h01, 8'h01, 8'h00);
		rd(8'h00, 8'h07, 8'h01);
		chk("no restart", 1'h0, stage.precharge_src);
		ana = '0;
		ana.bat_above_uvlo = 1'h1;
		ana.mid_above_margin = 1'h1;
		wr(8'h01, 8'h01);
		wait_bit(B_HIZ, 1'h1, SSC + 10);
		wr(8'h01, 8'h03);
		tick(10);
		chk("hiz wins", 1'h0, stage.precharge_src);
		// pin path, active low, with high impedance select set
		ana.mid_above_margin = 1'h0;
		pin_pol = 1'h0;
		pin = 1'h1;
		pin_en = 1'h1;
		wr(8'h01, 8'h02);
		tick(1);
		pin = 1'h0;
		wait_bit(B_PRE, 1'h1, 10);
		wait_bit(B_HIZ, 1'h1, PRE + 8);
		wait_bit(B_PRE, 1'h1, RST_C + 10);
		chk("restart delay", 1'h1, n >= RST_C - 4);
		wait_bit(B_HIZ, 1'h1, PRE + 8);
		wait_bit(B_PRE, 1'h1, RTY + 10);
		chk("retry delay", 1'h1, n >= RTY - 4);
		wait_bit(B_HIZ, 1'h1, PRE + 8);
		pin = 1'h1;
		tick(RTY + 10);
		chk("pin inactive", 1'h0, stage.precharge_src);
		end_sim();
	end
endmodule
bind bsq_boost_sequencer bsq_boost_sequencer_sva #(.PRECHG_CYC(PRECHG_CYC),
	.SS_CYC(SS_CYC)) sva_i (.clock(clock), .rst_b(rst_b), .serial_clk(serial_clk),
	.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .hs_mode_active(hs_mode_active),
	.boost_request_pin(boost_request_pin), .request_pin_enable(request_pin_enable),
	.request_pin_polarity(request_pin_polarity), .ana_in(ana_in),
	.stage_out(stage_out), .pfm_active(pfm_active));
